// *** air_defines.vh ***
// constants for the interrupt pin router
`ifndef AIR_DEFINES_VH
`define AIR_DEFINES_VH
// register offsets
`define AIR_OFS_ROUTE_MOTION 8'h19
`define AIR_OFS_ROUTE_NEWDATA 8'h1A
`define AIR_OFS_PIN_ELECTRICAL 8'h20
`define AIR_OFS_PIN_MODE 8'h21
// field positions
`define AIR_BIT_SIGMOT_ROUTE 0
`define AIR_BIT_SLOPE_ROUTE 2
`define AIR_BIT_NEWDATA_ROUTE 0
`define AIR_BIT_POLARITY 0
`define AIR_BIT_DRIVE 1
`define AIR_BIT_LATCH_CLR 7
`define AIR_MODE_MSB 3
// reset values
`define AIR_RST_POLARITY 1'b1
`define AIR_RST_DRIVE 1'b0
`define AIR_RST_MODE 4'h0
`define AIR_RDATA_ZERO 8'h00
// output mode low bits: 000 follows, 111 latched, rest timed
`define AIR_MODE_FOLLOW 3'h0
`define AIR_MODE_LATCHED 3'h7
// clock rate and hold times in microseconds
`define AIR_CLK_MHZ 25
`define AIR_T_250MS_US 250000
`define AIR_T_500MS_US 500000
`define AIR_T_1S_US 1000000
`define AIR_T_2S_US 2000000
`define AIR_T_4S_US 4000000
`define AIR_T_8S_US 8000000
`define AIR_T_250US_US 250
`define AIR_T_500US_US 500
`define AIR_T_1MS_US 1000
`define AIR_T_12MS5_US 12500
`define AIR_T_25MS_US 25000
`define AIR_T_50MS_US 50000
`define AIR_CNT_W 28
`endif

// *** air_host_model.sv ***
// host view of the interrupt pin, with a pull resistor on the line
`default_nettype none
module air_host_model (
    // pin from the router
    input wire logic pin_i,
    input wire logic oe_i,
    // polarity the host expects
    input wire logic active_high_i,
    // host verdict
    output logic asserted_o
);
    timeunit 1ns;
    timeprecision 1ns;
    // released line rests at the inactive level via its pull
    wire logic line_lvl = oe_i ? pin_i : ~active_high_i;
    assign asserted_o = (line_lvl === active_high_i);
endmodule
`default_nettype wire

// *** air_pin_hold.v ***
// hold stage: timed or latched stretch of the interrupt event
`default_nettype none
module air_pin_hold #(
    parameter CNT_W = 28
) (
    // clock and reset
    input wire core_clk_i,
    input wire rst_n_i,
    // control
    input wire trig_i,
    input wire clear_i,
    input wire latch_i,
    input wire [CNT_W-1:0] load_i,
    // state
    output wire held_o
);

reg [CNT_W-1:0] cnt_q;
reg latched_q;

////////////////////////////////////////////////////////////////////////
// timed hold: restart on each event, count down to zero
always @(posedge core_clk_i or negedge rst_n_i)
begin
    if (!rst_n_i)
        cnt_q <= {CNT_W{1'b0}};
    else if (trig_i && !latch_i)
        cnt_q <= load_i;
    else if (latch_i)
        cnt_q <= {CNT_W{1'b0}};
    else if (cnt_q != {CNT_W{1'b0}})
        cnt_q <= cnt_q - {{(CNT_W-1){1'b0}}, 1'b1};
end

// latched hold: a new event wins over a clear in the same cycle
always @(posedge core_clk_i or negedge rst_n_i)
begin
    if (!rst_n_i)
        latched_q <= 1'b0;
    else if (!latch_i)
        latched_q <= 1'b0;
    else if (trig_i)
        latched_q <= 1'b1;
    else if (clear_i)
        latched_q <= 1'b0;
end

assign held_o = latched_q | (cnt_q != {CNT_W{1'b0}});

endmodule
`default_nettype wire

// *** air_router.v ***
// interrupt pin router: source mapping, output mode, pin drive
`include "air_defines.vh"
`default_nettype none
module air_router #(
    parameter CNT_W = `AIR_CNT_W,
    parameter HOLD_250MS = `AIR_T_250MS_US * `AIR_CLK_MHZ,
    parameter HOLD_500MS = `AIR_T_500MS_US * `AIR_CLK_MHZ,
    parameter HOLD_1S = `AIR_T_1S_US * `AIR_CLK_MHZ,
    parameter HOLD_2S = `AIR_T_2S_US * `AIR_CLK_MHZ,
    parameter HOLD_4S = `AIR_T_4S_US * `AIR_CLK_MHZ,
    parameter HOLD_8S = `AIR_T_8S_US * `AIR_CLK_MHZ,
    parameter HOLD_250US = `AIR_T_250US_US * `AIR_CLK_MHZ,
    parameter HOLD_500US = `AIR_T_500US_US * `AIR_CLK_MHZ,
    parameter HOLD_1MS = `AIR_T_1MS_US * `AIR_CLK_MHZ,
    parameter HOLD_12MS5 = `AIR_T_12MS5_US * `AIR_CLK_MHZ,
    parameter HOLD_25MS = `AIR_T_25MS_US * `AIR_CLK_MHZ,
    parameter HOLD_50MS = `AIR_T_50MS_US * `AIR_CLK_MHZ
) (
    // clock and reset
    input wire core_clk_i,
    input wire rst_n_i,
    // register port from the serial front end
    input wire reg_wr_i,
    input wire reg_rd_i,
    input wire [7:0] reg_addr_i,
    input wire [7:0] reg_wdata_i,
    output reg [7:0] reg_rdata_o,
    // interrupt sources and their enables
    input wire sigmot_evt_i,
    input wire [2:0] slope_evt_i,
    input wire newdata_evt_i,
    input wire [2:0] slope_irq_enable_i,
    input wire newdata_irq_enable_i,
    // interrupt pin
    output reg interrupt_pin_one_o,
    output reg interrupt_pin_one_oe_o
);

reg rst_meta_q;
reg rst_sync_q;
reg significant_motion_route_q;
reg slope_route_q;
reg newdata_route_q;
reg pin_polarity_sel_q;
reg pin_drive_sel_q;
reg [3:0] mode_q;
reg src_prev_q;
reg [CNT_W-1:0] hold_len;
wire [2:0] mode_low;
wire latch_mode;
wire follow_mode;
wire latch_clr;
wire any_src;
wire trig;
wire held;
wire asserted;

////////////////////////////////////////////////////////////////////////
// reset release through two flops
always @(posedge core_clk_i or negedge rst_n_i)
begin
    if (!rst_n_i)
    begin
        rst_meta_q <= 1'b0;
        rst_sync_q <= 1'b0;
    end
    else
    begin
        rst_meta_q <= 1'b1;
        rst_sync_q <= rst_meta_q;
    end
end

////////////////////////////////////////////////////////////////////////
// register writes
always @(posedge core_clk_i or negedge rst_sync_q)
begin
    if (!rst_sync_q)
    begin
        significant_motion_route_q <= 1'b0;
        slope_route_q <= 1'b0;
        newdata_route_q <= 1'b0;
        pin_polarity_sel_q <= `AIR_RST_POLARITY;
        pin_drive_sel_q <= `AIR_RST_DRIVE;
        mode_q <= `AIR_RST_MODE;
    end
    else if (reg_wr_i)
    begin
        case (reg_addr_i)
            `AIR_OFS_ROUTE_MOTION:
            begin
                significant_motion_route_q <=
                    reg_wdata_i[`AIR_BIT_SIGMOT_ROUTE];
                slope_route_q <= reg_wdata_i[`AIR_BIT_SLOPE_ROUTE];
            end
            `AIR_OFS_ROUTE_NEWDATA:
                newdata_route_q <= reg_wdata_i[`AIR_BIT_NEWDATA_ROUTE];
            `AIR_OFS_PIN_ELECTRICAL:
            begin
                pin_polarity_sel_q <= reg_wdata_i[`AIR_BIT_POLARITY];
                pin_drive_sel_q <= reg_wdata_i[`AIR_BIT_DRIVE];
            end
            `AIR_OFS_PIN_MODE:
                mode_q <= reg_wdata_i[`AIR_MODE_MSB:0];
            default:
                mode_q <= mode_q; // unmapped writes are dropped
        endcase
    end
end

// register reads, reserved bits and the clear bit read as zero
always @(posedge core_clk_i or negedge rst_sync_q)
begin
    if (!rst_sync_q)
        reg_rdata_o <= `AIR_RDATA_ZERO;
    else if (reg_rd_i)
    begin
        reg_rdata_o <= `AIR_RDATA_ZERO;
        case (reg_addr_i)
            `AIR_OFS_ROUTE_MOTION:
            begin
                reg_rdata_o[`AIR_BIT_SIGMOT_ROUTE] <=
                    significant_motion_route_q;
                reg_rdata_o[`AIR_BIT_SLOPE_ROUTE] <= slope_route_q;
            end
            `AIR_OFS_ROUTE_NEWDATA:
                reg_rdata_o[`AIR_BIT_NEWDATA_ROUTE] <= newdata_route_q;
            `AIR_OFS_PIN_ELECTRICAL:
            begin
                reg_rdata_o[`AIR_BIT_POLARITY] <= pin_polarity_sel_q;
                reg_rdata_o[`AIR_BIT_DRIVE] <= pin_drive_sel_q;
            end
            `AIR_OFS_PIN_MODE:
                reg_rdata_o[`AIR_MODE_MSB:0] <= mode_q;
            default:
                reg_rdata_o <= `AIR_RDATA_ZERO;
        endcase
    end
end

////////////////////////////////////////////////////////////////////////
// latch clear strobe
assign latch_clr = reg_wr_i && (reg_addr_i == `AIR_OFS_PIN_MODE) &&
    reg_wdata_i[`AIR_BIT_LATCH_CLR];

// source gating and merge
// route gating
assign any_src = (sigmot_evt_i & significant_motion_route_q) |
    (|(slope_evt_i & slope_irq_enable_i) & slope_route_q) |
    (newdata_evt_i & newdata_irq_enable_i & newdata_route_q);

// rising edge of the merged source starts a hold
always @(posedge core_clk_i or negedge rst_sync_q)
begin
    if (!rst_sync_q)
        src_prev_q <= 1'b0;
    else
        src_prev_q <= any_src;
end

assign trig = any_src & ~src_prev_q;

////////////////////////////////////////////////////////////////////////
// mode decode
assign mode_low = mode_q[2:0];
assign follow_mode = (mode_low == `AIR_MODE_FOLLOW);
assign latch_mode = (mode_low == `AIR_MODE_LATCHED);

always @*
begin
    hold_len = {CNT_W{1'b0}};
    case ({mode_q[`AIR_MODE_MSB], mode_low})
        4'h1: hold_len = HOLD_250MS[CNT_W-1:0];
        4'h2: hold_len = HOLD_500MS[CNT_W-1:0];
        4'h3: hold_len = HOLD_1S[CNT_W-1:0];
        4'h4: hold_len = HOLD_2S[CNT_W-1:0];
        4'h5: hold_len = HOLD_4S[CNT_W-1:0];
        4'h6: hold_len = HOLD_8S[CNT_W-1:0];
        4'h9: hold_len = HOLD_250US[CNT_W-1:0];
        4'hA: hold_len = HOLD_500US[CNT_W-1:0];
        4'hB: hold_len = HOLD_1MS[CNT_W-1:0];
        4'hC: hold_len = HOLD_12MS5[CNT_W-1:0];
        4'hD: hold_len = HOLD_25MS[CNT_W-1:0];
        4'hE: hold_len = HOLD_50MS[CNT_W-1:0];
        default: hold_len = {CNT_W{1'b0}};
    endcase
end

// timed and latched stretching
air_pin_hold #(
    .CNT_W(CNT_W)
) u_hold (
    .core_clk_i(core_clk_i),
    .rst_n_i(rst_sync_q),
    .trig_i(trig),
    .clear_i(latch_clr),
    .latch_i(latch_mode),
    .load_i(hold_len),
    .held_o(held)
);

// follow mode uses the live source
assign asserted = follow_mode ? any_src : held;

////////////////////////////////////////////////////////////////////////
// pin drive
always @(posedge core_clk_i or negedge rst_sync_q)
begin
    if (!rst_sync_q)
    begin
        interrupt_pin_one_o <= ~`AIR_RST_POLARITY;
        interrupt_pin_one_oe_o <= 1'b1;
    end
    else
    begin
        interrupt_pin_one_o <= asserted ~^ pin_polarity_sel_q;
        interrupt_pin_one_oe_o <= pin_drive_sel_q ? asserted : 1'b1;
    end
end

endmodule
`default_nettype wire

// *** air_router_assertions.sv ***
// port checker for the interrupt pin router
`default_nettype none
module air_router_assertions (
    // clock, reset and register port
    input wire logic core_clk_i,
    input wire logic rst_n_i,
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    input wire logic [7:0] reg_addr_i,
    input wire logic [7:0] reg_wdata_i,
    input wire logic [7:0] reg_rdata_o,
    // sources
    input wire logic sigmot_evt_i,
    input wire logic [2:0] slope_evt_i,
    input wire logic newdata_evt_i,
    input wire logic [2:0] slope_irq_enable_i,
    input wire logic newdata_irq_enable_i,
    // pin
    input wire logic interrupt_pin_one_o,
    input wire logic interrupt_pin_one_oe_o
);
    timeunit 1ns;
    timeprecision 1ns;
    logic od_q, lv_q;
    logic [2:0] mode_q;
    logic [1:0] age_q;
    // config writes, and cycles with no possible source
    wire cfg_wr = reg_wr_i && reg_addr_i[7:1] == 7'h10;
    wire quiet = !sigmot_evt_i && !(|(slope_evt_i & slope_irq_enable_i))
        && !(newdata_evt_i && newdata_irq_enable_i);
    wire calm = age_q == 2'h0;
    // shadow of drive, polarity and mode; age masks the pin lag
    always_ff @(posedge core_clk_i or negedge rst_n_i)
        if (!rst_n_i)
        begin
            od_q <= 1'b0;
            lv_q <= 1'b1;
            mode_q <= 3'h0;
            age_q <= 2'h0;
        end
        else
        begin
            age_q <= {age_q[0], cfg_wr};
            if (reg_wr_i && reg_addr_i == 8'h20)
            begin
                od_q <= reg_wdata_i[1];
                lv_q <= reg_wdata_i[0];
            end
            if (reg_wr_i && reg_addr_i == 8'h21)
                mode_q <= reg_wdata_i[2:0];
        end
    default clocking @(posedge core_clk_i);
    endclocking
    default disable iff (!rst_n_i);
    sequence s_rd(logic [7:0] a);
        reg_rd_i && reg_addr_i == a;
    endsequence
    a_motion_route_resv:
        assert property (s_rd(8'h19) |=> (reg_rdata_o & 8'hFA) == 8'h00)
        else $error("motion route reserved bits set");
    a_data_route_resv:
        assert property (s_rd(8'h1A) |=> (reg_rdata_o & 8'hFE) == 8'h00)
        else $error("data route reserved bits set");
    a_elec_resv:
        assert property (s_rd(8'h20) |=> (reg_rdata_o & 8'hFC) == 8'h00)
        else $error("electrical reserved bits set");
    a_clear_reads_zero:
        assert property (s_rd(8'h21) |=> !reg_rdata_o[7])
        else $error("clear bit reads one");
    a_mode_resv:
        assert property (s_rd(8'h21) |=> reg_rdata_o[6:4] == 3'h0)
        else $error("mode reserved bits set");
    a_od_drive_level:
        assert property (calm && od_q && interrupt_pin_one_oe_o
            |-> interrupt_pin_one_o == lv_q)
        else $error("open drain drives inactive level");
    a_pp_always_on:
        assert property (calm && !od_q |-> interrupt_pin_one_oe_o)
        else $error("push pull pin not driven");
    a_idle_level:
        assert property (calm && !od_q && mode_q == 3'h0 && $past(quiet)
            && $past(quiet, 2) |-> interrupt_pin_one_o == !lv_q)
        else $error("idle pin not at inactive level");
endmodule
`default_nettype wire

// *** testbench.sv ***
// self-checking bench for the interrupt pin router
`default_nettype none
module testbench;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk = 0, rst_n = 0, wr = 0, rd = 0, sm = 0, nd = 0, ne = 0, hi = 1;
    logic [7:0] ad = 8'h00, wd = 8'h00;
    logic [2:0] sl = 3'h0, se = 3'h0;
    logic [7:0] lc[2] = '{8'h07, 8'h0F};
    logic [7:0] tc[12] = '{8'h01, 8'h02, 8'h03, 8'h04, 8'h05, 8'h06,
        8'h09, 8'h0A, 8'h0B, 8'h0C, 8'h0D, 8'h0E};
    int hold[12] = '{10, 12, 14, 16, 18, 20, 22, 24, 26, 28, 30, 32};
    wire [7:0] rdat;
    wire pin, oe, act;
    int fail_count = 0, samples_checked = 0;
    // clock
    always #20 clk = ~clk;
    // design with short, distinct hold times per code, and the host
    air_router #(.HOLD_250MS(10), .HOLD_500MS(12), .HOLD_1S(14),
        .HOLD_2S(16), .HOLD_4S(18), .HOLD_8S(20), .HOLD_250US(22),
        .HOLD_500US(24), .HOLD_1MS(26), .HOLD_12MS5(28), .HOLD_25MS(30),
        .HOLD_50MS(32)) air_router_inst (
        .core_clk_i(clk), .rst_n_i(rst_n), .reg_wr_i(wr), .reg_rd_i(rd),
        .reg_addr_i(ad), .reg_wdata_i(wd), .reg_rdata_o(rdat),
        .sigmot_evt_i(sm), .slope_evt_i(sl), .newdata_evt_i(nd),
        .slope_irq_enable_i(se), .newdata_irq_enable_i(ne),
        .interrupt_pin_one_o(pin), .interrupt_pin_one_oe_o(oe));
    air_host_model air_host_model_inst (.pin_i(pin), .oe_i(oe),
        .active_high_i(hi), .asserted_o(act));
    task automatic check(input logic [7:0] seen, exp);
        samples_checked++;
        if (seen !== exp)
        begin
            fail_count++;
            $display("FAIL at %0t seen %h exp %h", $time, seen, exp);
        end
    endtask
    task automatic wr_reg(input logic [7:0] a, d);
        @(negedge clk);
        wr = 1;
        ad = a;
        wd = d;
        @(negedge clk);
        wr = 0;
    endtask
    task automatic rd_reg(input logic [7:0] a, exp);
        @(negedge clk);
        rd = 1;
        ad = a;
        @(negedge clk);
        rd = 0;
        @(negedge clk);
        check(rdat, exp);
    endtask
    task automatic pin_is(input logic exp);
        repeat (3) @(negedge clk);
        check({7'h00, act}, {7'h00, exp});
    endtask
    task automatic finish_test;
        $display("checks %0d mismatches %0d", samples_checked, fail_count);
        if (fail_count == 0 && samples_checked > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    // watchdog
    initial
    begin
        #200000;
        fail_count++;
        finish_test;
    end
    // tests
    initial
    begin
        repeat (16) @(negedge clk);
        rst_n = 1;
        repeat (3) @(negedge clk);
        rd_reg(8'h20, 8'h01);
        rd_reg(8'h21, 8'h00);
        rd_reg(8'h19, 8'h00);
        wr_reg(8'h19, 8'hFF);
        rd_reg(8'h19, 8'h05);
        wr_reg(8'h1A, 8'hFF);
        rd_reg(8'h1A, 8'h01);
        $display("registers done");
        sm = 1;
        pin_is(1);
        wr_reg(8'h19, 8'h04);
        pin_is(0);
        sm = 0;
        sl = 3'h1;
        pin_is(0);
        se = 3'h1;
        pin_is(1);
        wr_reg(8'h19, 8'h00);
        pin_is(0);
        sl = 3'h0;
        nd = 1;
        pin_is(0);
        ne = 1;
        pin_is(1);
        wr_reg(8'h1A, 8'h00);
        pin_is(0);
        wr_reg(8'h1A, 8'h01);
        wr_reg(8'h20, 8'h00);
        hi = 0;
        pin_is(1);
        nd = 0;
        pin_is(0);
        wr_reg(8'h20, 8'h03);
        hi = 1;
        pin_is(0);
        check({7'h00, oe}, 8'h00);
        nd = 1;
        pin_is(1);
        nd = 0;
        wr_reg(8'h20, 8'h01);
        $display("routing and pin done");
        for (int i = 0; i < 2; i++)
        begin
            wr_reg(8'h21, lc[i]);
            nd = 1;
            @(negedge clk);
            nd = 0;
            pin_is(1);
            pin_is(1);
            wr_reg(8'h21, lc[i] | 8'h80);
            pin_is(0);
            rd_reg(8'h21, lc[i]);
        end
        // an event in the same cycle as the clear keeps the pin latched
        @(negedge clk);
        wr = 1;
        ad = 8'h21;
        wd = 8'h8F;
        nd = 1;
        @(negedge clk);
        wr = 0;
        nd = 0;
        pin_is(1);
        wr_reg(8'h21, 8'h8F);
        pin_is(0);
        // last high sample and first low sample of each timed code
        for (int i = 0; i < 12; i++)
        begin
            wr_reg(8'h21, tc[i]);
            nd = 1;
            @(negedge clk);
            nd = 0;
            repeat (hold[i]) @(negedge clk);
            check({7'h00, act}, 8'h01);
            @(negedge clk);
            check({7'h00, act}, 8'h00);
        end
        wr_reg(8'h21, 8'h08);
        nd = 1;
        pin_is(1);
        nd = 0;
        pin_is(0);
        $display("output modes done");
        finish_test;
    end
endmodule
bind air_router air_router_assertions air_router_assertions_inst (.*);
`default_nettype wire
